/* File: rtl/pspc_top.sv */
// Command port of a pressure and temperature sensor: core logic on the
// reference clock plus the serial link end on the master's SCL.
// Assumes an analog front end that presents a settled sample on
// ADC_SAMPLE at conversion end, and static calibration bits on PROM_IMAGE.
//
// Operation
// - Device answers address 111011C; C is the inverted address select pin.
// - Reset command is accepted and acted on at any moment.
// - Memory read: write the command, then read the word separately.
// - Device stays busy until a conversion completes; result follows then.
// - After address acknowledge the master clocks out 24 result bits.
// - Device waits for master acknowledge after each 8 bits.
// - Calibration memory holds 128 bits with a 4-bit CRC.
// - Memory word 0 holds 16 bits of maker data.
// - Words 1 to 6 hold coefficients, word 7 holds the CRC.
// - Protocol select high picks this serial link, low picks the other.
// - Commands are single bytes: reset, result read, memory read.
// - Conversion commands pick channel and oversampling 256 to 4096.
// - Result reads zero when stale, repeated or mid-conversion; overlaps corrupt.
`timescale 1ns/1ps
`include "pspc_map.svh"
module pspc_top #(
  parameter int CONV_BASE_CYC = `PSPC_CONV_BASE_CYC
) (
  // Reference clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Serial link
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Straps
  input wire logic ADDR_SEL,
  input wire logic PROTO_SEL,
  // Analog front end
  input wire logic [23:0] ADC_SAMPLE,
  output logic ADC_START,
  output logic ADC_CHAN,
  output logic [2:0] ADC_OSR,
  output logic BUSY,
  // Factory calibration bits
  input wire logic [127:0] PROM_IMAGE
);
  pspc_pkg::pspc_core_t q_ff, nxt_q;
  logic lk_cmd_tgl;
  logic [7:0] lk_cmd;
  logic cmd_new;
  logic is_reset;
  logic is_read;
  logic is_prom;
  logic is_conv;
  logic [15:0] prom_sel;
  logic overlap;

  // Link end on SCL; commands come back as a toggle with a held byte
  pspc_i2c_link u_link (
    .scl_clk(SCL),
    .rstn(RSTN),
    .sda_i(SDA_I),
    .addr_sel_pin(ADDR_SEL),
    .proto_sel_pin(PROTO_SEL),
    .sda_oe(SDA_OE),
    .cmd_tgl(lk_cmd_tgl),
    .cmd(lk_cmd),
    .reply(q_ff.reply)
  );

  // The byte is read only once the toggle has passed two flops, so it
  // has stood still for at least one full reference cycle by then
  assign cmd_new = q_ff.cmd_sync != q_ff.cmd_seen;
  assign is_reset = lk_cmd == `PSPC_CMD_RESET;
  assign is_read = lk_cmd == `PSPC_CMD_ADC_READ;
  assign is_prom = lk_cmd[`PSPC_CMD_GRP_HI:`PSPC_CMD_GRP_LO] == `PSPC_CMD_PROM_GRP &&
                   !lk_cmd[`PSPC_CMD_STOP_BIT];
  assign is_conv = (lk_cmd[`PSPC_CMD_GRP_HI:`PSPC_CMD_GRP_LO] == `PSPC_CMD_CONV_P_GRP ||
                    lk_cmd[`PSPC_CMD_GRP_HI:`PSPC_CMD_GRP_LO] == `PSPC_CMD_CONV_T_GRP) &&
                   lk_cmd[`PSPC_CMD_SEL_HI:`PSPC_CMD_SEL_LO] <= `PSPC_OSR_MAX &&
                   !lk_cmd[`PSPC_CMD_STOP_BIT];
  assign prom_sel = q_ff.prom[lk_cmd[`PSPC_CMD_SEL_HI:`PSPC_CMD_SEL_LO]];
  // Read or conversion command that lands on a running conversion
  assign overlap = cmd_new && (is_read || is_conv);

  // Command decode and conversion timing
  always_comb begin
    nxt_q = q_ff;
    nxt_q.cmd_meta = lk_cmd_tgl;
    nxt_q.cmd_sync = q_ff.cmd_meta;
    nxt_q.adc_start = 1'b0;
    nxt_q.sda_o = 1'b0;
    // Conversion countdown; a corrupted run still ends on time
    if (q_ff.busy) begin
      if (q_ff.cnt == 22'h000000) begin
        nxt_q.busy = 1'b0;
        nxt_q.valid = 1'b1;
        // An overlap in the very last cycle still spoils the sample
        nxt_q.result = (q_ff.corrupt || overlap) ?
                       {~ADC_SAMPLE[23], ADC_SAMPLE[22:0]} : ADC_SAMPLE;
      end else begin
        nxt_q.cnt = q_ff.cnt - 22'h000001;
      end
    end
    if (cmd_new) begin
      nxt_q.cmd_seen = q_ff.cmd_sync;
      if (is_reset) begin
        // Reset overrides any running conversion
        nxt_q.busy = 1'b0;
        nxt_q.valid = 1'b0;
        nxt_q.corrupt = 1'b0;
        nxt_q.cnt = 22'h000000;
        nxt_q.result = `PSPC_RST_RESULT;
        nxt_q.reply = `PSPC_RST_REPLY;
        // Load all eight words, CRC bits included
        for (int w = 0; w < `PSPC_PROM_WORDS; w++) begin
          nxt_q.prom[w] = PROM_IMAGE[w*`PSPC_PROM_WORD_W +: `PSPC_PROM_WORD_W];
        end
      end else if (is_read) begin
        // Stale, repeated or mid-conversion read answers zero
        nxt_q.reply = (q_ff.valid && !q_ff.busy) ? q_ff.result : `PSPC_RST_REPLY;
        // A result landing in this same cycle stays valid: set wins
        if (q_ff.busy) begin
          nxt_q.corrupt = 1'b1;
        end else begin
          nxt_q.valid = 1'b0;
        end
      end else if (is_prom) begin
        // Word goes out in the top two bytes
        nxt_q.reply = {prom_sel, 8'h00};
      end else if (is_conv) begin
        if (q_ff.busy) begin
          nxt_q.corrupt = 1'b1;
        end else begin
          // Channel from bit 4, oversampling step from bits 3..1
          nxt_q.busy = 1'b1;
          nxt_q.valid = 1'b0;
          nxt_q.corrupt = 1'b0;
          nxt_q.adc_start = 1'b1;
          nxt_q.chan = lk_cmd[`PSPC_CMD_GRP_LO];
          nxt_q.osr = lk_cmd[`PSPC_CMD_SEL_HI:`PSPC_CMD_SEL_LO];
          nxt_q.cnt = 22'((CONV_BASE_CYC << lk_cmd[`PSPC_CMD_SEL_HI:`PSPC_CMD_SEL_LO]) - 1);
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // All outputs come straight from state flops
  assign SDA_O = q_ff.sda_o;
  assign ADC_START = q_ff.adc_start;
  assign ADC_CHAN = q_ff.chan;
  assign ADC_OSR = q_ff.osr;
  assign BUSY = q_ff.busy;

  a_reset_any_time: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (cmd_new && is_reset) |=> (!BUSY && !q_ff.valid && q_ff.reply == 24'h000000))
    else $error("reset command not honoured");

  a_busy_no_result: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    BUSY |-> !q_ff.valid)
    else $error("result valid while converting");

  a_conv_done: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (BUSY && q_ff.cnt == 22'h000000 && !(cmd_new && is_reset))
    |=> (!BUSY && q_ff.valid))
    else $error("conversion end not flagged");

  a_read_zero: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (cmd_new && is_read && (BUSY || !q_ff.valid)) |=> (q_ff.reply == 24'h000000))
    else $error("stale result read not zero");

  a_read_result: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (cmd_new && is_read && !BUSY && q_ff.valid)
    |=> (q_ff.reply == $past(q_ff.result) && !q_ff.valid))
    else $error("result read wrong or not consumed");

  a_prom_reply: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (cmd_new && is_prom) |=> (q_ff.reply[23:8] == $past(prom_sel) && q_ff.reply[7:0] == 8'h00))
    else $error("memory word not staged");

  a_conv_start: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (cmd_new && is_conv && !BUSY)
    |=> (BUSY && ADC_START && ADC_OSR == $past(lk_cmd[3:1])) ##1 !ADC_START)
    else $error("conversion start wrong");

  a_overlap_corrupt: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (cmd_new && (is_conv || is_read) && BUSY)
    |=> (BUSY ? q_ff.corrupt : (q_ff.valid && q_ff.result[23] != $past(ADC_SAMPLE[23]))))
    else $error("overlapping command not flagged");

  a_start_one_pulse: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ADC_START |-> (BUSY && !$past(BUSY)))
    else $error("conversion start not a single pulse");

  a_mode_held: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (BUSY && !ADC_START) |-> ($stable(ADC_CHAN) && $stable(ADC_OSR)))
    else $error("conversion mode changed while busy");

  a_reply_hold: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !cmd_new |=> $stable(q_ff.reply))
    else $error("staged reply changed without a command");

endmodule : pspc_top

/* File: rtl/pspc_map.svh */
// Constants of the pressure sensor command port: address, command codes,
// field positions, reset values and conversion timing.
// Assumes the includer works on the 125 MHz reference clock.
`ifndef PSPC_MAP_SVH
`define PSPC_MAP_SVH

// Fixed upper six bits of the 7-bit bus address
`define PSPC_ADDR_BASE 6'h3b

// Command bytes and command groups
`define PSPC_CMD_RESET 8'h1e
`define PSPC_CMD_ADC_READ 8'h00
`define PSPC_CMD_PROM_GRP 4'ha
`define PSPC_CMD_CONV_P_GRP 4'h4
`define PSPC_CMD_CONV_T_GRP 4'h5
`define PSPC_OSR_MAX 3'h4

// Field positions inside a command byte
`define PSPC_CMD_GRP_HI 7
`define PSPC_CMD_GRP_LO 4
`define PSPC_CMD_SEL_HI 3
`define PSPC_CMD_SEL_LO 1
`define PSPC_CMD_STOP_BIT 0

// Calibration memory shape; CRC sits in the low bits of the last word
`define PSPC_PROM_WORDS 8
`define PSPC_PROM_WORD_W 16
`define PSPC_CRC_W 4
`define PSPC_RESULT_W 24

// Reset values
`define PSPC_RST_REPLY 24'h000000
`define PSPC_RST_RESULT 24'h000000

// Conversion time at the lowest oversampling, doubled per step
`define PSPC_REF_PERIOD_NS 8
`define PSPC_CONV_BASE_NS 600000
`define PSPC_CONV_BASE_CYC (`PSPC_CONV_BASE_NS / `PSPC_REF_PERIOD_NS)

`endif

/* File: rtl/pspc_pkg.sv */
// Types of the pressure sensor command port.
// Assumes pspc_map.svh supplies the numeric constants.
package pspc_pkg;

  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ACK_ADDR, LK_WCMD, LK_ACK_CMD, LK_TX, LK_MACK
  } pspc_link_st_t;

  typedef struct packed {
    pspc_link_st_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [23:0] tx;
    logic cmd_tgl;
    logic [7:0] cmd;
    logic start_seen;
    logic ps_meta;
    logic ps_ff;
    logic as_meta;
    logic as_ff;
  } pspc_link_t;

  typedef struct packed {
    logic cmd_meta;
    logic cmd_sync;
    logic cmd_seen;
    logic busy;
    logic corrupt;
    logic valid;
    logic chan;
    logic [2:0] osr;
    logic [21:0] cnt;
    logic [23:0] result;
    logic [23:0] reply;
    logic [7:0][15:0] prom;
    logic adc_start;
    logic sda_o;
  } pspc_core_t;

endpackage : pspc_pkg

/* File: rtl/pspc_i2c_link.sv */
// Serial link end of the command port, clocked by the master's SCL.
// Assumes SDA is sampled on rising SCL and driven on falling SCL;
// the SCL clock may stand still between frames.
`timescale 1ns/1ps
`include "pspc_map.svh"
module pspc_i2c_link (
  // Link clock and reset
  input wire logic scl_clk,
  input wire logic rstn,
  // Pins
  input wire logic sda_i,
  input wire logic addr_sel_pin,
  input wire logic proto_sel_pin,
  output logic sda_oe,
  // Command toward the core; cmd is stable while cmd_tgl stands
  output logic cmd_tgl,
  output logic [7:0] cmd,
  // Reply word from the core, held stable between commands
  input wire logic [23:0] reply
);
  pspc_pkg::pspc_link_t q_ff, nxt_q;
  logic start_tgl_ff;
  logic oe_ff;
  logic [7:0] sb;
  logic new_start;

  // Start marker: SDA falling while SCL is high, caught on SDA's own edge
  always_ff @(negedge sda_i or negedge rstn) begin
    if (!rstn) begin
      start_tgl_ff <= 1'b0;
    end else if (scl_clk) begin
      start_tgl_ff <= ~start_tgl_ff;
    end
  end

  assign sb = {q_ff.sh[6:0], sda_i};
  assign new_start = start_tgl_ff != q_ff.start_seen;

  // Bit and byte framing on rising SCL
  always_comb begin
    nxt_q = q_ff;
    nxt_q.ps_meta = proto_sel_pin;
    nxt_q.ps_ff = q_ff.ps_meta;
    nxt_q.as_meta = addr_sel_pin;
    nxt_q.as_ff = q_ff.as_meta;
    if (new_start) begin
      // A fresh start resyncs a stuck link
      nxt_q.start_seen = start_tgl_ff;
      nxt_q.sh = {7'h00, sda_i};
      nxt_q.cnt = 3'h1;
      nxt_q.st = q_ff.ps_ff ? pspc_pkg::LK_ADDR : pspc_pkg::LK_IDLE;
    end else begin
      unique case (q_ff.st)
        pspc_pkg::LK_IDLE: begin
        end
        pspc_pkg::LK_ADDR: begin
          nxt_q.sh = sb;
          nxt_q.cnt = q_ff.cnt + 3'h1;
          if (q_ff.cnt == 3'h7) begin
            // Address bit 1 is the inverse of the select pin
            nxt_q.st = (sb[7:1] == {`PSPC_ADDR_BASE, ~q_ff.as_ff}) ?
                       pspc_pkg::LK_ACK_ADDR : pspc_pkg::LK_IDLE;
          end
        end
        pspc_pkg::LK_ACK_ADDR: begin
          nxt_q.cnt = 3'h0;
          if (q_ff.sh[0]) begin
            nxt_q.tx = reply;
            nxt_q.st = pspc_pkg::LK_TX;
          end else begin
            nxt_q.st = pspc_pkg::LK_WCMD;
          end
        end
        pspc_pkg::LK_WCMD: begin
          nxt_q.sh = sb;
          nxt_q.cnt = q_ff.cnt + 3'h1;
          if (q_ff.cnt == 3'h7) begin
            nxt_q.cmd = sb;
            nxt_q.cmd_tgl = ~q_ff.cmd_tgl;
            nxt_q.st = pspc_pkg::LK_ACK_CMD;
          end
        end
        pspc_pkg::LK_ACK_CMD: begin
          nxt_q.cnt = 3'h0;
          nxt_q.st = pspc_pkg::LK_WCMD;
        end
        pspc_pkg::LK_TX: begin
          // Shift out MSB first
          nxt_q.tx = {q_ff.tx[22:0], 1'b0};
          nxt_q.cnt = q_ff.cnt + 3'h1;
          if (q_ff.cnt == 3'h7) begin
            nxt_q.st = pspc_pkg::LK_MACK;
          end
        end
        pspc_pkg::LK_MACK: begin
          // Low means acknowledge: next byte; high ends output
          nxt_q.cnt = 3'h0;
          nxt_q.st = sda_i ? pspc_pkg::LK_IDLE : pspc_pkg::LK_TX;
        end
        default: begin
          nxt_q.st = pspc_pkg::LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Drive on falling SCL so SDA settles during the low phase
  always_ff @(negedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= (q_ff.st == pspc_pkg::LK_ACK_ADDR) || (q_ff.st == pspc_pkg::LK_ACK_CMD) ||
               ((q_ff.st == pspc_pkg::LK_TX) && !q_ff.tx[23]);
    end
  end

  assign sda_oe = oe_ff;
  assign cmd_tgl = q_ff.cmd_tgl;
  assign cmd = q_ff.cmd;

  a_addr_ack_match: assert property (
    @(posedge scl_clk) disable iff (!rstn)
    (q_ff.st == pspc_pkg::LK_ADDR && q_ff.cnt == 3'h7 && !new_start &&
     sb[7:1] == {`PSPC_ADDR_BASE, ~q_ff.as_ff}) |=> (q_ff.st == pspc_pkg::LK_ACK_ADDR))
    else $error("matching address not acknowledged");

  a_tx_load_msb: assert property (
    @(posedge scl_clk) disable iff (!rstn)
    (q_ff.st == pspc_pkg::LK_ACK_ADDR && q_ff.sh[0] && !new_start)
    |=> (q_ff.tx == $past(reply)) ##1 (q_ff.tx[23] == $past(q_ff.tx[22])))
    else $error("reply not shifted out msb first");

  a_byte_pause_ack: assert property (
    @(posedge scl_clk) disable iff (!rstn)
    (q_ff.st == pspc_pkg::LK_TX && q_ff.cnt == 3'h7 && !new_start)
    |=> (q_ff.st == pspc_pkg::LK_MACK))
    else $error("no pause for master acknowledge");

  a_proto_gate: assert property (
    @(posedge scl_clk) disable iff (!rstn)
    (new_start && !q_ff.ps_ff) |=> (q_ff.st == pspc_pkg::LK_IDLE))
    else $error("link active with other protocol selected");

endmodule : pspc_i2c_link

/* File: test/pspc_i2c_master.sv */
// Bus master model that drives the command port's serial link.
// Assumes the bench resolves an open-drain SDA wire with a pull-up.
`timescale 1ns/1ps
module pspc_i2c_master (
  // Link clock, stands high between frames
  output logic scl,
  // High while the master pulls SDA low
  output logic sda_pull,
  // Resolved wire level
  input wire logic sda
);
  localparam int HALF = 24;

  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // One bit: data set while SCL is low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #4 sda_pull = ~b;
    #(HALF - 4) scl = 1'b1;
    #(HALF / 2) r = sda;
    #(HALF / 2) scl = 1'b0;
  endtask : bit_io

  // Start, also usable as a repeated start
  task automatic start_c;
    #4 sda_pull = 1'b0;
    #(HALF - 4) scl = 1'b1;
    #HALF sda_pull = 1'b1;
    #HALF scl = 1'b0;
  endtask : start_c

  // Stop; leaves the clock standing high
  task automatic stop_c;
    #4 sda_pull = 1'b1;
    #(HALF - 4) scl = 1'b1;
    #HALF sda_pull = 1'b0;
    #HALF;
  endtask : stop_c

  // Byte out, MSB first, then the device's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send

  // Write frame carrying one command byte
  task automatic wr_cmd(input logic [6:0] a, input logic [7:0] c, output logic ok);
    logic aa;
    logic ac;
    ac = 1'b0;
    start_c();
    send({a, 1'b0}, aa);
    if (aa) send(c, ac);
    stop_c();
    ok = aa & ac;
  endtask : wr_cmd

  // Read frame of n bytes; every byte acked but the last
  task automatic rd(input logic [6:0] a, input int n, output logic ok, output logic [23:0] d);
    logic r;
    d = 24'h000000;
    start_c();
    send({a, 1'b1}, ok);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        bit_io(1'b1, r);
        d = {d[22:0], r};
      end
      bit_io(k == n - 1, r);
    end
    stop_c();
  endtask : rd

  // Bare clocks with SDA released, to settle straps or free a stuck bus
  task automatic pulses(input int n);
    logic r;
    for (int i = 0; i < n; i++) bit_io(1'b1, r);
    #4 scl = 1'b1;
  endtask : pulses
endmodule : pspc_i2c_master

/* File: test/tb_pressure_sensor_i2c_command_port.sv */
// Self-checking bench of the sensor command port.
// Assumes pspc_top and the master model; SDA has a pull-up.
`timescale 1ns/1ps
module tb_pressure_sensor_i2c_command_port;
  typedef struct packed {
    logic [7:0] cmd;
    logic [23:0] smp;
    logic [23:0] exp;
  } pspc_row_t;
  localparam int CONV = 20;
  logic ref_clk = 1'b0;
  logic rstn, scl, sda_pull, sda, sda_o, sda_oe, addr_sel, proto_sel;
  logic adc_start, adc_chan, busy, st_chan, ok;
  logic [2:0] adc_osr, st_osr;
  logic [23:0] adc_sample;
  logic [127:0] prom;
  pspc_row_t rows [18];
  int n_errors = 0;
  int compares = 0;
  int n_start = 0;
  int busy_cyc = 0;

  always #4 ref_clk = ~ref_clk;
  // Open-drain wire with pull-up
  assign sda = (sda_pull | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

  pspc_i2c_master m_u (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  pspc_top #(.CONV_BASE_CYC(CONV)) dut_u (
    .REF_CLK(ref_clk), .RSTN(rstn), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .ADDR_SEL(addr_sel), .PROTO_SEL(proto_sel),
    .ADC_SAMPLE(adc_sample), .ADC_START(adc_start), .ADC_CHAN(adc_chan),
    .ADC_OSR(adc_osr), .BUSY(busy), .PROM_IMAGE(prom));

  // Note what each start presented and how long BUSY stood
  always @(posedge ref_clk) begin
    if (adc_start === 1'b1) begin
      n_start++;
      st_chan = adc_chan;
      st_osr = adc_osr;
      busy_cyc = 1;
    end else if (busy === 1'b1) begin
      busy_cyc++;
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // Bounded wait; a hang ends the run
  task automatic wait_idle;
    int i;
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge ref_clk);
    if (i == 3000) begin
      n_errors++;
      $display("[FAIL] %0t busy stuck", $time);
      end_sim();
    end
  endtask : wait_idle

  task automatic cmd(input logic [7:0] c);
    m_u.wr_cmd({6'h3b, ~addr_sel}, c, ok);
    check(24'(ok), 24'h1, "cmd ack");
  endtask : cmd

  task automatic fetch(input int n, input logic [23:0] exp, input string what);
    logic [23:0] d;
    m_u.rd({6'h3b, ~addr_sel}, n, ok, d);
    check(24'(ok), 24'h1, "read ack");
    check(d, exp, what);
  endtask : fetch

  task automatic set_smp(input logic [23:0] s);
    @(posedge ref_clk);
    #1 adc_sample = s;
  endtask : set_smp

  initial begin
    int k;
    rstn = 1'b0;
    addr_sel = 1'b0;
    proto_sel = 1'b1;
    adc_sample = 24'h000000;
    for (int w = 0; w < 8; w++) prom[16 * w +: 16] = 16'h1234 + 16'(w * 16'h0f01);
    for (int i = 0; i < 18; i++) begin
      rows[i].smp = 24'ha5c301 ^ 24'(i * 24'h111111);
      rows[i].cmd = {3'h2, 1'(i / 5), 3'(i % 5), 1'b0};
      rows[i].exp = rows[i].smp;
      if (i >= 10) rows[i].cmd = {4'ha, 3'(i - 10), 1'b0};
      if (i >= 10) rows[i].exp = {8'h00, prom[16 * (i - 10) +: 16]};
    end
    repeat (8) @(posedge ref_clk);
    check({21'h0, adc_start, busy, sda_oe}, 24'h0, "outputs in reset");
    #1 rstn = 1'b1;
    m_u.pulses(2);
    cmd(8'ha2);
    fetch(2, 24'h0, "memory before reset cmd");
    cmd(8'h1e);
    cmd(8'h00);
    fetch(3, 24'h0, "read with no conversion");
    $display("Reset tests done");
    // Table: every conversion code, then every memory word
    foreach (rows[r]) begin
      set_smp(rows[r].smp);
      k = n_start;
      cmd(rows[r].cmd);
      if (rows[r].cmd[7:4] != 4'ha) begin
        wait_idle();
        check(24'(n_start - k), 24'h1, "one start");
        check(24'({st_osr, st_chan}), 24'({rows[r].cmd[3:1], rows[r].cmd[4]}), "mode");
        k = CONV << rows[r].cmd[3:1];
        check(24'(busy_cyc >= k - 1 && busy_cyc <= k + 2), 24'h1, "busy length");
        cmd(8'h00);
      end
      fetch(rows[r].cmd[7:4] == 4'ha ? 2 : 3, rows[r].exp, "row data");
      $display("Row %0d done", r);
    end
    cmd(8'h00);
    fetch(3, 24'h0, "repeated read");
    // Read mid-conversion gives zero and spoils the result
    set_smp(24'h3c5a96);
    cmd(8'h48);
    cmd(8'h00);
    fetch(3, 24'h0, "read while busy");
    wait_idle();
    cmd(8'h00);
    fetch(3, 24'hbc5a96, "spoiled result");
    // Second conversion command mid-run does not restart but spoils
    k = n_start;
    cmd(8'h48);
    cmd(8'h50);
    wait_idle();
    check(24'(n_start - k), 24'h1, "no restart");
    cmd(8'h00);
    fetch(3, 24'hbc5a96, "conversion overlap");
    // Reset command in mid-conversion
    cmd(8'h48);
    cmd(8'h1e);
    wait_idle();
    cmd(8'h00);
    fetch(3, 24'h0, "read after reset");
    $display("Overlap tests done");
    // Pin reset in mid-conversion clears outputs and memory
    cmd(8'h48);
    @(posedge ref_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    check({17'h0, adc_start, busy, sda_oe, adc_chan, adc_osr}, 24'h0, "pin reset outputs");
    #1 rstn = 1'b1;
    m_u.pulses(2);
    cmd(8'haa);
    fetch(2, 24'h0, "memory after pin reset");
    cmd(8'h1e);
    // Oversampling step 5 is no conversion code
    cmd(8'h4a);
    check(24'(busy), 24'h0, "undefined code ignored");
    $display("Pin reset tests done");
    // Address bit follows the inverted select pin
    addr_sel = 1'b1;
    m_u.pulses(2);
    m_u.wr_cmd(7'h77, 8'h00, ok);
    check(24'(ok), 24'h0, "wrong address");
    cmd(8'h00);
    addr_sel = 1'b0;
    // Protocol select low ignores frames
    proto_sel = 1'b0;
    m_u.pulses(2);
    m_u.wr_cmd(7'h77, 8'h00, ok);
    check(24'(ok), 24'h0, "link off");
    proto_sel = 1'b1;
    m_u.pulses(2);
    // Frame cut at the acknowledge, then freed by clocks
    m_u.start_c();
    // Address 0x77 with the read bit is 8'hef: only bit 4 is low
    for (int i = 7; i >= 0; i--) m_u.bit_io(i != 4, ok);
    #30;
    check(24'(sda), 24'h0, "held at ack");
    m_u.pulses(9);
    check(24'(sda), 24'h1, "bus freed");
    cmd(8'h1e);
    $display("Link tests done");
    end_sim();
  end
endmodule : tb_pressure_sensor_i2c_command_port
